// ### rtl/ata_sector_command_engine.sv
// Card-side command engine for translate, wear level and sector writes.
// Assumes the media side answers translate and commit requests later.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
module ata_sector_command_engine import ata_cmd_pkg::*; #(
	parameter bit SECURITY = 1'b0
) (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	// Task-file link
	ata_tf_if.dev            tf,
	// Multiple-mode setting from the set-multiple handler
	input  wire logic        mult_set_i,
	input  wire logic [7:0]  mult_count_i,
	// Translate lookup
	output logic             xlat_req_o,
	output logic [27:0]      xlat_lba_o,
	input  wire logic        xlat_ack_i,
	input  wire logic [15:0] xlat_cyl_i,
	input  wire logic [3:0]  xlat_head_i,
	input  wire logic [7:0]  xlat_sec_i,
	input  wire logic        xlat_erased_i,
	input  wire logic [23:0] xlat_hot_i,
	// Write stream and commit
	output logic             wr_valid_o,
	output logic             wr_ecc_o,
	output logic             wr_to_buf_o,
	output logic [15:0]      wr_data_o,
	output logic             commit_o,
	output logic [27:0]      commit_lba_o,
	input  wire logic        commit_done_i,
	input  wire logic        commit_err_i,
	// Security state
	output logic             frozen_o
);
	typedef enum logic [2:0] {S_IDLE, S_EXEC, S_XWAIT, S_XDRQ, S_WDRQ, S_WECC, S_COMMIT} state_t;
	typedef struct packed {
		state_t      state;
		logic [7:0]  cmd;
		logic [7:0]  seccnt;
		logic [7:0]  secnum;
		logic [7:0]  cyl_lo;
		logic [7:0]  cyl_hi;
		logic [7:0]  drvhd;
		logic [7:0]  err_reg;
		logic        bsy;
		logic        drq;
		logic        err;
		logic        intrq;
		logic        rvalid;
		logic [15:0] rdata;
		logic        mult_en;
		logic [7:0]  mult_size;
		logic [7:0]  blk_cur;
		logic [7:0]  blk_left;
		logic [8:0]  remaining;
		logic [7:0]  widx;
		logic [7:0]  ridx;
		logic [1:0]  eidx;
		logic        long_cmd;
		logic        buf_only;
		logic        xlat_req;
		logic [15:0] i_cyl;
		logic [3:0]  i_head;
		logic [7:0]  i_sec;
		logic        i_erased;
		logic [23:0] i_hot;
		logic        wr_valid;
		logic        wr_ecc;
		logic [15:0] wr_data;
		logic        commit;
		logic        frozen;
	} st_t;

	st_t         s;
	st_t         next_s;
	logic        rd;
	logic        wr;
	logic [7:0]  status;
	logic [27:0] lba;
	logic [27:0] lba_inc;
	logic [8:0]  rem_dec;

	// ==========================================================
	// Translate buffer contents
	function automatic logic [7:0] xlat_byte(input logic [8:0] i, input st_t v);
		logic [7:0] b;
		b = 8'h00;
		unique case (i)
			XB_CYL_HI: b = v.i_cyl[15:8];
			XB_CYL_LO: b = v.i_cyl[7:0];
			XB_HEAD:   b = {4'h0, v.i_head};
			XB_SEC:    b = v.i_sec;
			XB_LBA2:   b = {v.cyl_hi};
			XB_LBA1:   b = v.cyl_lo;
			XB_LBA0:   b = v.secnum;
			XB_ERASED: b = v.i_erased ? ERASED_YES : ERASED_NO;
			XB_HOT2:   b = v.i_hot[23:16];
			XB_HOT1:   b = v.i_hot[15:8];
			XB_HOT0:   b = v.i_hot[7:0];
			default:   b = 8'h00;
		endcase
		return b;
	endfunction

	assign lba     = {s.drvhd[3:0], s.cyl_hi, s.cyl_lo, s.secnum};
	assign lba_inc = lba + 28'h000_0001;
	assign rem_dec = s.remaining - 9'h001;
	assign status  = {s.bsy, ~s.bsy, 1'b0, 1'b1, s.drq, 2'b00, s.err};
	assign rd      = tf.req && !tf.we;
	assign wr      = tf.req && tf.we;

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.rvalid = 1'b0;
		next_s.xlat_req = 1'b0;
		next_s.wr_valid = 1'b0;
		next_s.wr_ecc = 1'b0;
		next_s.commit = 1'b0;
		if (mult_set_i) begin
			// Only block size one is accepted; anything else disables
			next_s.mult_en = (mult_count_i != 8'h00) && (mult_count_i <= BLOCK_MAX);
			next_s.mult_size = mult_count_i;
		end
		if (rd) begin
			next_s.rvalid = 1'b1;
			unique case (tf.addr)
				TF_DATA:   next_s.rdata = {xlat_byte({s.ridx, 1'b1}, s), xlat_byte({s.ridx, 1'b0}, s)};
				TF_ERR:    next_s.rdata = {8'h00, s.err_reg};
				TF_SECCNT: next_s.rdata = {8'h00, s.seccnt};
				TF_SECNUM: next_s.rdata = {8'h00, s.secnum};
				TF_CYLLO:  next_s.rdata = {8'h00, s.cyl_lo};
				TF_CYLHI:  next_s.rdata = {8'h00, s.cyl_hi};
				TF_DRVHD:  next_s.rdata = {8'h00, s.drvhd};
				TF_CMD: begin
					next_s.rdata = {8'h00, status};
					next_s.intrq = 1'b0;
				end
			endcase
		end
		unique case (s.state)
			S_IDLE: begin
				if (wr) begin
					case (tf.addr)
						TF_SECCNT: next_s.seccnt = tf.wdata[7:0];
						TF_SECNUM: next_s.secnum = tf.wdata[7:0];
						TF_CYLLO:  next_s.cyl_lo = tf.wdata[7:0];
						TF_CYLHI:  next_s.cyl_hi = tf.wdata[7:0];
						TF_DRVHD:  next_s.drvhd = tf.wdata[7:0];
						TF_CMD: begin
							next_s.cmd = tf.wdata[7:0];
							next_s.bsy = 1'b1;
							next_s.err = 1'b0;
							next_s.err_reg = 8'h00;
							next_s.intrq = 1'b0;
							next_s.state = S_EXEC;
						end
						default: ;
					endcase
				end
			end
			S_EXEC: begin
				next_s.widx = 8'h00;
				next_s.ridx = 8'h00;
				next_s.eidx = 2'h0;
				next_s.long_cmd = (s.cmd == CMD_WLONG0) || (s.cmd == CMD_WLONG1);
				next_s.buf_only = (s.cmd == CMD_WBUF);
				next_s.blk_cur = (s.cmd == CMD_WMULT) ? s.mult_size : 8'h01;
				next_s.blk_left = next_s.blk_cur;
				next_s.remaining = (s.seccnt == 8'h00) ? FULL_COUNT : {1'b0, s.seccnt};
				case (s.cmd)
					CMD_XLAT: begin
						next_s.xlat_req = 1'b1;
						next_s.state = S_XWAIT;
					end
					CMD_WEAR: begin
						next_s.seccnt = 8'h00;
						if (SECURITY)
							next_s.frozen = 1'b1;
						next_s.bsy = 1'b0;
						next_s.intrq = 1'b1;
						next_s.state = S_IDLE;
					end
					CMD_WBUF, CMD_WLONG0, CMD_WLONG1, CMD_WMULT, CMD_WSEC0, CMD_WSEC1: begin
						if (s.cmd == CMD_WMULT && !s.mult_en) begin
							next_s.err = 1'b1;
							next_s.err_reg[ER_ABRT] = 1'b1;
							next_s.bsy = 1'b0;
							next_s.intrq = 1'b1;
							next_s.state = S_IDLE;
						end else begin
							if (next_s.long_cmd || next_s.buf_only)
								next_s.remaining = 9'h001;
							next_s.bsy = 1'b0;
							next_s.drq = 1'b1;
							next_s.state = S_WDRQ;
						end
					end
					default: begin
						next_s.err = 1'b1;
						next_s.err_reg[ER_ABRT] = 1'b1;
						next_s.bsy = 1'b0;
						next_s.intrq = 1'b1;
						next_s.state = S_IDLE;
					end
				endcase
			end
			S_XWAIT: begin
				if (xlat_ack_i) begin
					next_s.i_cyl = xlat_cyl_i;
					next_s.i_head = xlat_head_i;
					next_s.i_sec = xlat_sec_i;
					next_s.i_erased = xlat_erased_i;
					next_s.i_hot = xlat_hot_i;
					next_s.bsy = 1'b0;
					next_s.drq = 1'b1;
					next_s.intrq = 1'b1;
					next_s.state = S_XDRQ;
				end
			end
			S_XDRQ: begin
				if (rd && tf.addr == TF_DATA) begin
					next_s.ridx = s.ridx + 8'h01;
					if (s.ridx == LAST_WORD) begin
						next_s.drq = 1'b0;
						next_s.state = S_IDLE;
					end
				end
			end
			S_WDRQ: begin
				// Byte-wide writes during the word phase are dropped
				if (wr && tf.addr == TF_DATA && !tf.byte_mode) begin
					next_s.wr_valid = 1'b1;
					next_s.wr_data = tf.wdata;
					next_s.widx = s.widx + 8'h01;
					if (s.widx == LAST_WORD) begin
						next_s.drq = 1'b0;
						if (s.long_cmd) begin
							next_s.drq = 1'b1;
							next_s.state = S_WECC;
						end else if (s.buf_only) begin
							next_s.intrq = 1'b1;
							next_s.state = S_IDLE;
						end else begin
							next_s.bsy = 1'b1;
							next_s.commit = 1'b1;
							next_s.state = S_COMMIT;
						end
					end
				end
			end
			S_WECC: begin
				if (wr && tf.addr == TF_DATA && tf.byte_mode) begin
					next_s.wr_valid = 1'b1;
					next_s.wr_ecc = 1'b1;
					next_s.wr_data = {8'h00, tf.wdata[7:0]};
					next_s.eidx = s.eidx + 2'h1;
					if (s.eidx == LAST_ECC) begin
						next_s.drq = 1'b0;
						next_s.bsy = 1'b1;
						next_s.commit = 1'b1;
						next_s.state = S_COMMIT;
					end
				end
			end
			S_COMMIT: begin
				if (commit_done_i) begin
					next_s.widx = 8'h00;
					next_s.eidx = 2'h0;
					next_s.bsy = 1'b0;
					if (commit_err_i) begin
						// Address and count still name the failing sector
						next_s.err = 1'b1;
						next_s.err_reg[ER_WRITE] = 1'b1;
						next_s.seccnt = s.remaining[7:0];
						next_s.intrq = 1'b1;
						next_s.state = S_IDLE;
					end else begin
						next_s.remaining = rem_dec;
						next_s.seccnt = rem_dec[7:0];
						{next_s.drvhd[3:0], next_s.cyl_hi, next_s.cyl_lo, next_s.secnum} = lba_inc;
						next_s.blk_left = s.blk_left - 8'h01;
						if (rem_dec == 9'h000) begin
							next_s.intrq = 1'b1;
							next_s.state = S_IDLE;
						end else begin
							next_s.drq = 1'b1;
							next_s.state = S_WDRQ;
							if (s.blk_left == 8'h01) begin
								next_s.blk_left = s.blk_cur;
								next_s.intrq = 1'b1;
							end
						end
					end
				end
			end
		endcase
	end

	// ==========================================================
	// State register; reset also clears multiple mode
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign tf.rdata     = s.rdata;
	assign tf.rvalid    = s.rvalid;
	assign tf.intrq     = s.intrq;
	assign xlat_req_o   = s.xlat_req;
	assign xlat_lba_o   = lba;
	assign wr_valid_o   = s.wr_valid;
	assign wr_ecc_o     = s.wr_ecc;
	assign wr_to_buf_o  = s.buf_only;
	assign wr_data_o    = s.wr_data;
	assign commit_o     = s.commit;
	assign commit_lba_o = lba;
	assign frozen_o     = s.frozen;
endmodule

// ### rtl/ata_cmd_pkg.sv
// Shared constants for the task-file command engine and its host end.
// Assumes a single 50 MHz clock shared by both ends.
package ata_cmd_pkg;
	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_XLAT   = 8'h87;
	localparam logic [7:0] CMD_WEAR   = 8'hF5;
	localparam logic [7:0] CMD_WBUF   = 8'hE8;
	localparam logic [7:0] CMD_WLONG0 = 8'h32;
	localparam logic [7:0] CMD_WLONG1 = 8'h33;
	localparam logic [7:0] CMD_WMULT  = 8'hC5;
	localparam logic [7:0] CMD_WSEC0  = 8'h30;
	localparam logic [7:0] CMD_WSEC1  = 8'h31;
	// ==========================================================
	// Task-file addresses
	localparam logic [2:0] TF_DATA   = 3'h0;
	localparam logic [2:0] TF_ERR    = 3'h1;
	localparam logic [2:0] TF_SECCNT = 3'h2;
	localparam logic [2:0] TF_SECNUM = 3'h3;
	localparam logic [2:0] TF_CYLLO  = 3'h4;
	localparam logic [2:0] TF_CYLHI  = 3'h5;
	localparam logic [2:0] TF_DRVHD  = 3'h6;
	localparam logic [2:0] TF_CMD    = 3'h7;
	localparam logic [7:0] DRVHD_LBA = 8'hE0;
	// ==========================================================
	// Status and error bits
	localparam int ST_BSY   = 7;
	localparam int ST_DRDY  = 6;
	localparam int ST_DSC   = 4;
	localparam int ST_DRQ   = 3;
	localparam int ST_ERR   = 0;
	localparam int ER_ABRT  = 2;
	localparam int ER_WRITE = 4;
	// ==========================================================
	// Transfer sizes
	localparam logic [7:0] LAST_WORD  = 8'hFF;
	localparam logic [1:0] LAST_ECC   = 2'h3;
	localparam logic [8:0] FULL_COUNT = 9'h100;
	localparam logic [7:0] BLOCK_MAX  = 8'h01;
	// ==========================================================
	// Translate buffer layout
	localparam logic [8:0] XB_CYL_HI = 9'h000;
	localparam logic [8:0] XB_CYL_LO = 9'h001;
	localparam logic [8:0] XB_HEAD   = 9'h002;
	localparam logic [8:0] XB_SEC    = 9'h003;
	localparam logic [8:0] XB_LBA2   = 9'h004;
	localparam logic [8:0] XB_LBA1   = 9'h005;
	localparam logic [8:0] XB_LBA0   = 9'h006;
	localparam logic [8:0] XB_ERASED = 9'h013;
	localparam logic [8:0] XB_HOT2   = 9'h018;
	localparam logic [8:0] XB_HOT1   = 9'h019;
	localparam logic [8:0] XB_HOT0   = 9'h01A;
	localparam logic [7:0] ERASED_YES = 8'hFF;
	localparam logic [7:0] ERASED_NO  = 8'h00;
	// ==========================================================
	// Timing
	localparam int CLK_NS      = 20;
	localparam int BSY_MAX_NS  = 400;
	localparam int BSY_MAX_CYC = BSY_MAX_NS / CLK_NS;
	// ==========================================================
	// Host APB map
	localparam logic [7:0] HR_CTRL   = 8'h00;
	localparam logic [7:0] HR_ADDR   = 8'h04;
	localparam logic [7:0] HR_COUNT  = 8'h08;
	localparam logic [7:0] HR_STATUS = 8'h0C;
	localparam logic [7:0] HR_CAP    = 8'h40;
	localparam int CAP_WORDS = 16;
endpackage

// ### rtl/ata_tf_if.sv
// Task-file link between host controller and card command engine.
// Single shared clock; one request per cycle, read answers one cycle later.
`timescale 1ns/1ps
interface ata_tf_if;
	logic        req;
	logic        we;
	logic        byte_mode;
	logic [2:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        rvalid;
	logic        intrq;
	modport dev  (input req, we, byte_mode, addr, wdata, output rdata, rvalid, intrq);
	modport host (output req, we, byte_mode, addr, wdata, input rdata, rvalid, intrq);
endinterface

// ### rtl/ata_host_ctrl.sv
// Host controller end: runs one task-file command per software order.
// Assumes an APB master; one wait state on every access.
`timescale 1ns/1ps
module ata_host_ctrl import ata_cmd_pkg::*; (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Task-file link
	ata_tf_if.host           tf
);
	typedef enum logic [2:0] {H_IDLE, H_TF, H_POLL, H_DATA, H_WAIT, H_ERR, H_CNT} hstate_t;
	typedef struct packed {
		hstate_t     state;
		hstate_t     after;
		logic [7:0]  cmd;
		logic [27:0] lba;
		logic [7:0]  count;
		logic [15:0] pattern;
		logic        busy;
		logic        fail;
		logic [7:0]  err_byte;
		logic [7:0]  res_cnt;
		logic [2:0]  tfi;
		logic [8:0]  k;
		logic        req;
		logic        we;
		logic        byte_mode;
		logic [2:0]  addr;
		logic [15:0] wdata;
		logic [CAP_WORDS-1:0][15:0] cap;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} hst_t;

	hst_t       h;
	hst_t       next_h;
	logic       is_long;
	logic       is_read;
	logic [8:0] xfer_len;

	assign is_long  = (h.cmd == CMD_WLONG0) || (h.cmd == CMD_WLONG1);
	assign is_read  = (h.cmd == CMD_XLAT);
	assign xfer_len = is_long ? 9'h104 : FULL_COUNT;

	always_comb begin
		next_h = h;
		next_h.req = 1'b0;
		next_h.pslverr = 1'b0;
		// ======================================================
		// APB: answer on the cycle after the first access cycle
		next_h.pready = psel_i && penable_i && !h.pready;
		if (psel_i && penable_i && !h.pready) begin
			next_h.pslverr = !(paddr_i inside {HR_CTRL, HR_ADDR, HR_COUNT, HR_STATUS})
				&& (paddr_i[7:6] != 2'b01);
			unique case (paddr_i)
				HR_CTRL:   next_h.prdata = {24'h00_0000, h.cmd};
				HR_ADDR:   next_h.prdata = {4'h0, h.lba};
				HR_COUNT:  next_h.prdata = {h.pattern, 8'h00, h.count};
				HR_STATUS: next_h.prdata = {8'h00, h.res_cnt, h.err_byte, 6'h00, h.fail, h.busy};
				default:   next_h.prdata = (paddr_i[7:6] == 2'b01)
					? {16'h0000, h.cap[paddr_i[5:2]]} : 32'h0000_0000;
			endcase
		end
		if (psel_i && penable_i && h.pready && pwrite_i && !h.busy) begin
			case (paddr_i)
				HR_CTRL: begin
					next_h.cmd = pwdata_i[7:0];
					next_h.busy = 1'b1;
					next_h.fail = 1'b0;
					next_h.tfi = 3'h0;
					next_h.state = H_TF;
				end
				HR_ADDR:  next_h.lba = pwdata_i[27:0];
				HR_COUNT: begin
					next_h.count = pwdata_i[7:0];
					next_h.pattern = pwdata_i[31:16];
				end
				default: ;
			endcase
		end
		// ======================================================
		// Command engine
		unique case (h.state)
			H_IDLE: ;
			H_TF: begin
				next_h.req = 1'b1;
				next_h.we = 1'b1;
				next_h.byte_mode = 1'b0;
				next_h.tfi = h.tfi + 3'h1;
				unique case (h.tfi)
					3'h0: {next_h.addr, next_h.wdata} = {TF_DRVHD, 8'h00, DRVHD_LBA | {4'h0, h.lba[27:24]}};
					3'h1: {next_h.addr, next_h.wdata} = {TF_CYLHI, 8'h00, h.lba[23:16]};
					3'h2: {next_h.addr, next_h.wdata} = {TF_CYLLO, 8'h00, h.lba[15:8]};
					3'h3: {next_h.addr, next_h.wdata} = {TF_SECNUM, 8'h00, h.lba[7:0]};
					3'h4: {next_h.addr, next_h.wdata} = {TF_SECCNT, 8'h00, h.count};
					default: begin
						{next_h.addr, next_h.wdata} = {TF_CMD, 8'h00, h.cmd};
						next_h.state = H_WAIT;
						next_h.after = H_POLL;
					end
				endcase
			end
			H_POLL: begin
				next_h.req = 1'b1;
				next_h.we = 1'b0;
				next_h.addr = TF_CMD;
				next_h.state = H_WAIT;
				next_h.after = H_POLL;
			end
			H_DATA: begin
				// One DRQ check per block, then the whole block
				next_h.req = 1'b1;
				next_h.we = !is_read;
				next_h.addr = TF_DATA;
				next_h.byte_mode = h.k[8];
				next_h.wdata = h.pattern + {7'h00, h.k};
				next_h.k = h.k + 9'h001;
				if (is_read) begin
					next_h.state = H_WAIT;
					next_h.after = H_DATA;
				end else if (next_h.k == xfer_len) begin
					next_h.state = H_WAIT;
					next_h.after = H_POLL;
				end
			end
			H_WAIT: begin
				if (h.we && !h.req) begin
					next_h.state = h.after;
				end else if (tf.rvalid) begin
					next_h.state = h.after;
					if (h.addr == TF_DATA) begin
						if (h.k <= 9'(CAP_WORDS))
							next_h.cap[h.k[3:0] - 4'h1] = tf.rdata;
						if (h.k == FULL_COUNT)
							next_h.state = H_POLL;
					end else if (h.addr == TF_CMD) begin
						if (tf.rdata[ST_BSY])
							next_h.state = H_POLL;
						else if (tf.rdata[ST_DRQ]) begin
							next_h.k = 9'h000;
							next_h.state = H_DATA;
						end else begin
							next_h.fail = tf.rdata[ST_ERR];
							next_h.state = H_ERR;
						end
					end else if (h.addr == TF_ERR) begin
						next_h.err_byte = tf.rdata[7:0];
						next_h.state = H_CNT;
					end else begin
						next_h.res_cnt = tf.rdata[7:0];
						next_h.busy = 1'b0;
						next_h.state = H_IDLE;
					end
				end
			end
			H_ERR, H_CNT: begin
				next_h.req = 1'b1;
				next_h.we = 1'b0;
				next_h.addr = (h.state == H_ERR) ? TF_ERR : TF_SECCNT;
				next_h.state = H_WAIT;
			end
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			h <= '0;
		else
			h <= next_h;
	end

	assign prdata_o     = h.prdata;
	assign pready_o     = h.pready;
	assign pslverr_o    = h.pslverr;
	assign tf.req       = h.req;
	assign tf.we        = h.we;
	assign tf.byte_mode = h.byte_mode;
	assign tf.addr      = h.addr;
	assign tf.wdata     = h.wdata;
endmodule

// ### tb/ata_tf_props.sv
// Checker on the task-file link between the host and card ends.
// Assumes both ends share clock_i and rst_i.
`timescale 1ns/1ps
module ata_tf_props import ata_cmd_pkg::*; (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	// Task-file link
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic        byte_mode,
	input  wire logic [2:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] rdata,
	input  wire logic        rvalid,
	input  wire logic        intrq
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	// ==============================
	// Helper state
	logic [8:0] words;
	logic [2:0] bytes;
	logic       first;
	logic       wear;
	wire        cmd = req && we && addr == TF_CMD;
	wire        dw  = req && we && addr == TF_DATA;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			words <= '0;
			bytes <= '0;
			first <= 1'b0;
			wear <= 1'b0;
		end else if (cmd) begin
			words <= '0;
			bytes <= '0;
			first <= wdata[7:0] inside {CMD_WSEC0, CMD_WSEC1, CMD_WBUF, CMD_WLONG0, CMD_WLONG1};
			wear <= wdata[7:0] == CMD_WEAR;
		end else if (dw) begin
			words <= words + {8'h00, !byte_mode};
			bytes <= bytes + {2'h0, byte_mode};
			first <= 1'b0;
		end
	end
	// ==============================
	// Properties
	sequence s_cmd; cmd; endsequence
	sequence s_stat; rvalid && $past(addr) == TF_CMD; endsequence
	property p_rd_ans; req && !we |=> rvalid; endproperty
	property p_rd_only; rvalid |-> $past(req) && !$past(we); endproperty
	property p_excl; s_stat |-> !(rdata[ST_BSY] && rdata[ST_DRQ]); endproperty
	property p_first; first && $past(first) |-> !intrq; endproperty
	property p_clr; s_cmd |-> ##[1:2] !intrq; endproperty
	property p_lorder; dw && byte_mode |-> words == 9'h100; endproperty
	property p_lcnt; dw && byte_mode |-> bytes < 3'h4; endproperty
	property p_wear; wear && rvalid && $past(addr) == TF_SECCNT |-> rdata[7:0] == 8'h00; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
	a_rd_only: assert property (p_rd_only) else $error("stray answer");
	a_excl: assert property (p_excl) else $error("busy with drq");
	a_first: assert property (p_first) else $error("first interrupt");
	a_clr: assert property (p_clr) else $error("interrupt kept");
	a_lorder: assert property (p_lorder) else $error("byte too early");
	a_lcnt: assert property (p_lcnt) else $error("too many bytes");
	a_wear: assert property (p_wear) else $error("wear count");
endmodule

// ### tb/ata_sector_command_engine_tb.sv
// Bench: software drives the host end over APB; the bench plays the media.
// Assumes one 50 MHz clock for both ends and the checker.
`timescale 1ns/1ps
module ata_sector_command_engine_tb import ata_cmd_pkg::*; ;
	localparam logic [7:0] WC[5] = '{CMD_WSEC0, CMD_WSEC1, CMD_WLONG0, CMD_WLONG1, CMD_WBUF};
	logic        clock_i = 0;
	logic        rst_i = 1;
	logic        psel = 0, penable = 0, pwrite = 0, mset = 0, xack = 0, cdone = 0, cerr = 0;
	logic        xer = 0, pready, pslverr, se, xreq, wv, wecc, wbuf, com, frozen;
	logic [7:0]  paddr = 0, mcnt = 0, xsec = 0;
	logic [31:0] pwdata = 0, prdata, st, rs = 6998;
	logic [15:0] xcyl = 0, wdat, pat;
	logic [3:0]  xhead = 0;
	logic [23:0] xhot = 0;
	logic [27:0] xlba, clba, lba;
	logic [19:0] junk;
	logic [17:0] e, eq[$];
	logic [27:0] cq[$];
	logic [7:0]  xb[32];
	int          mismatches = 0, comparisons = 0, fail_at = 0, ncom = 0;
	ata_tf_if tf ();
	ata_sector_command_engine i_ata_sector_command_engine (
		.clock_i, .rst_i, .tf(tf), .mult_set_i(mset), .mult_count_i(mcnt),
		.xlat_req_o(xreq), .xlat_lba_o(xlba), .xlat_ack_i(xack), .xlat_cyl_i(xcyl),
		.xlat_head_i(xhead), .xlat_sec_i(xsec), .xlat_erased_i(xer), .xlat_hot_i(xhot),
		.wr_valid_o(wv), .wr_ecc_o(wecc), .wr_to_buf_o(wbuf), .wr_data_o(wdat),
		.commit_o(com), .commit_lba_o(clba), .commit_done_i(cdone), .commit_err_i(cerr),
		.frozen_o(frozen));
	ata_host_ctrl i_ata_host_ctrl (.clock_i, .rst_i, .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .tf(tf));
	ata_tf_props i_ata_tf_props (.clock_i, .rst_i, .req(tf.req), .we(tf.we),
		.byte_mode(tf.byte_mode), .addr(tf.addr), .wdata(tf.wdata), .rdata(tf.rdata),
		.rvalid(tf.rvalid), .intrq(tf.intrq));
	always #10 clock_i = ~clock_i;
	// ==============================
	// Helpers
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clock_i);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		st = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		if (pready !== 1'b1) begin
			chk("pready", 1, 0);
			give_verdict();
		end
	endtask
	task automatic prep(input logic [7:0] n);
		{pat, lba, junk} = {xs(), xs()};
		apb(1, HR_ADDR, {4'h0, lba});
		apb(1, HR_COUNT, {pat, 8'h00, n});
	endtask
	// Poll until idle; busy never clearing ends the run
	task automatic run(input logic [7:0] c);
		int n = 0;
		apb(1, HR_CTRL, {24'h00_0000, c});
		do begin
			apb(0, HR_STATUS, 0);
			n++;
		end while (st[0] !== 1'b0 && n < 3000);
		if (st[0] !== 1'b0) begin
			chk("idle", 1, 0);
			give_verdict();
		end
	endtask
	task automatic expw(input logic [7:0] c, input int n);
		logic b;
		b = c == CMD_WBUF;
		for (int k = 0; k < 256 * n; k++)
			eq.push_back({b, 1'b0, pat + 16'(k % 256)});
		if (c == CMD_WLONG0 || c == CMD_WLONG1)
			for (int k = 256; k < 260; k++)
				eq.push_back({2'b01, 8'h00, 8'(pat + 16'(k))});
		for (int s = 0; s < n && !b; s++)
			cq.push_back(lba + 28'(s));
	endtask
	// ==============================
	// Media side and result watcher
	always @(posedge clock_i) begin
		if (wv === 1'b1) begin
			e = eq.size() ? eq.pop_front() : ~{wbuf, wecc, wdat};
			chk("wr_word", e, {wbuf, wecc, wecc ? {8'h00, wdat[7:0]} : wdat});
		end
	end
	always @(posedge clock_i) begin
		if (com === 1'b1) begin
			ncom++;
			chk("commit_lba", cq.size() ? cq.pop_front() : ~clba, clba);
			repeat (xs() % 4) @(posedge clock_i);
			cdone <= 1;
			cerr <= ncom == fail_at;
			@(posedge clock_i);
			cdone <= 0;
			cerr <= 0;
		end
	end
	always @(posedge clock_i) begin
		if (xreq === 1'b1) begin
			chk("xlat_lba", lba, xlba);
			repeat (xs() % 8) @(posedge clock_i);
			xack <= 1;
			@(posedge clock_i);
			xack <= 0;
		end
	end
	// ==============================
	// Main sequence
	initial begin
		repeat (12) @(posedge clock_i);
		rst_i <= 0;
		apb(0, HR_STATUS, 0);
		chk("status_rst", 0, st);
		apb(0, 8'h20, 0);
		chk("unmapped_err", 1, se);
		prep(8'h02);
		run(CMD_WMULT);
		chk("abort_status", 16'h0402, st[15:0]);
		$display("test reset and abort done");
		mcnt <= BLOCK_MAX;
		mset <= 1;
		@(posedge clock_i);
		mset <= 0;
		// Write long only when ordered, here as a
		for (int c = 0; c < 5; c++) begin
			prep(8'h01);
			expw(WC[c], 1);
			run(WC[c]);
			chk("single_status", {(WC[c] == CMD_WBUF) ? 8'h01 : 8'h00, 16'h0000}, st[23:0]);
			chk("single_left", 0, eq.size() + cq.size());
			$display("test write %h done", WC[c]);
		end
		for (int f = 0; f < 2; f++) begin
			prep(f ? 8'h04 : 8'h03);
			fail_at = f ? 2 : 0;
			ncom = 0;
			expw(CMD_WMULT, f ? 2 : 3);
			run(CMD_WMULT);
			chk("mult_status", f ? 24'h03_1002 : 24'h00_0000, st[23:0]);
			chk("err_lba", f ? lba + 28'h000_0001 : lba + 28'h000_0003, xlba);
			chk("mult_left", 0, eq.size() + cq.size());
			$display("test write multiple %0d done", f);
		end
		rst_i <= 1;
		@(posedge clock_i);
		rst_i <= 0;
		prep(8'h01);
		run(CMD_WMULT);
		chk("abort_after_rst", 16'h0402, st[15:0]);
		$display("test mid-run reset done");
		fail_at = 0;
		for (int t = 0; t < 2; t++) begin
			prep(8'h01);
			{xcyl, xsec, junk[7:0]} <= xs();
			{xhead, xhot, junk[11:8]} <= t ? 32'h0000_0000 : xs();
			xer <= t[0];
			run(CMD_XLAT);
			xb = '{default: 8'h00};
			{xb[0], xb[1], xb[2], xb[3]} = {xcyl, 4'h0, xhead, xsec};
			{xb[4], xb[5], xb[6]} = lba[23:0];
			xb[19] = xer ? ERASED_YES : ERASED_NO;
			{xb[24], xb[25], xb[26]} = xhot;
			for (int i = 0; i < 16; i++) begin
				apb(0, HR_CAP + 8'(4 * i), 0);
				chk("xlat_word", {xb[2 * i + 1], xb[2 * i]}, st[15:0]);
			end
			$display("test translate %0d done", t);
		end
		prep(8'h05);
		run(CMD_WEAR);
		chk("wear_status", 0, st[23:0]);
		chk("frozen", 0, frozen);
		$display("test wear done");
		give_verdict();
	end
endmodule
